// File: logic/frc_secded.sv
// Single-error-correct, double-error-detect check of one 64-bit flash word
`timescale 1ns/100ps

module frc_secded
  import frc_pkg::*;
(
  frc_ecc_if.chk e
);

  // ==========================================================================
  // Hamming positions 1..71, check bit k at position 2**k, ecc[7] is overall parity
  logic [71:1] cw;
  logic [6:0]  syn;
  logic        par;
  int          di;
  int          ci;

  always_comb begin
    cw  = '0;
    syn = 7'h00;
    di  = 0;
    ci  = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) == 0) begin
        cw[p] = e.ecc[ci[2:0]];
        ci    = ci + 1;
      end else begin
        cw[p] = e.data[di[5:0]];
        di    = di + 1;
      end
    end
    for (int p = 1; p < 72; p++) begin
      if (cw[p]) begin
        syn = syn ^ p[6:0];
      end
    end
    par   = ^{cw, e.ecc[7]};
    e.sbe = par;
    e.dbe = !par && (syn != 7'h00);
    // Flip the one bad bit; a syndrome of zero means the parity bit itself was hit
    if (par && (syn != 7'h00) && (syn < 7'h48)) begin
      cw[syn] = !cw[syn];
    end
    di = 0;
    e.fixed = 64'h0000_0000_0000_0000;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        e.fixed[di[5:0]] = cw[p];
        di               = di + 1;
      end
    end
  end

endmodule

// File: logic/frc_top.sv
// Flash read path: instruction prefetch buffer, data line cache and ECC checking
//
// What this block does
// - Prefetch mode is switchable and with it off every fetch pays a full flash access.
// - With prefetch on, 128-bit aligned lines are fetched ahead from the last fetched line.
// - Prefetched lines sit in a buffer of two 128-bit entries.
// - The buffer keeps refilling while fetches are served from it without wait cycles.
// - Only a fetch that misses the buffer pays wait cycles.
// - A data read with the cache on loads the whole aligned 128-bit line.
// - Data reads that hit the cached line answer with no wait cycles.
// - A data read that misses drops the cached line and loads the new one.
// - With the data cache off every data read goes to flash with full wait cycles.
// - Each 64-bit flash word is checked for one correctable and two detectable bit errors.
// - ECC correction sits in the read path and adds no cycle to an access.
// - An uncorrectable error raises the non-maskable interrupt.
// - Reaching the corrected-error threshold raises a maskable interrupt.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`include "frc_defines.svh"

module frc_top
  import frc_pkg::*;
(
  input  wire logic                    i_core_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_clk_en,
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [`FRC_PADDR_W-1:0] i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  input  wire logic                    i_if_req,
  input  wire logic [`FRC_IF_AW-1:0]   i_if_addr,
  output logic                         o_if_ack,
  output logic      [15:0]             o_if_data,
  input  wire logic                    i_dr_req,
  input  wire logic [`FRC_DR_AW-1:0]   i_dr_addr,
  output logic                         o_dr_ack,
  output logic      [31:0]             o_dr_data,
  output logic                         o_flash_req,
  output logic      [`FRC_LINE_W-1:0]  o_flash_addr,
  input  wire logic [127:0]            i_flash_data,
  input  wire logic [15:0]             i_flash_ecc,
  output logic                         o_nmi,
  output logic                         o_irq
);

  localparam frc_regs_t RST = '{st: FRC_IDLE, kind: FRC_K_IF, wait_cycles: `FRC_WAIT_RST,
                                thr: `FRC_THR_RST, default: '0};

  frc_regs_t                r;
  frc_regs_t                n;
  logic [`FRC_LINE_W-1:0]   if_line;
  logic [`FRC_LINE_W-1:0]   dr_line;
  logic                     hit0;
  logic                     hit1;
  logic                     if_hit;
  logic                     dr_hit;
  logic                     if_take;
  logic                     dr_take;
  logic                     acc_done;
  logic [127:0]             fixed_line;
  logic [127:0]             hit_line;
  logic                     fs;
  logic [1:0]               sbe_inc;
  logic                     dbe_ev;
  logic                     thr_ev;
  logic                     apb_setup;
  logic                     apb_acc;
  logic                     cnt_clr;
  logic [15:0]              cnt_base;
  logic [16:0]              cnt_sum;
  logic [15:0]              sat_cnt;
  logic [1:0]               rd_clr;
  logic [31:0]              rd_val;
  logic                     mapped;

  // ==========================================================================
  // ECC slices, one per 64-bit half of the line
  frc_ecc_if ecc_lo ();
  frc_ecc_if ecc_hi ();

  frc_secded u_ecc_lo (
    .e (ecc_lo.chk)
  );

  frc_secded u_ecc_hi (
    .e (ecc_hi.chk)
  );

  assign ecc_lo.data = i_flash_data[63:0];
  assign ecc_lo.ecc  = i_flash_ecc[7:0];
  assign ecc_hi.data = i_flash_data[127:64];
  assign ecc_hi.ecc  = i_flash_ecc[15:8];
  assign fixed_line  = {ecc_hi.fixed, ecc_lo.fixed};

  // ==========================================================================
  // Lookups
  assign if_line  = i_if_addr[`FRC_IF_AW-1:3];
  assign dr_line  = i_dr_addr[`FRC_DR_AW-1:2];
  assign hit0     = r.pv[0] && (r.pline[0] == if_line);
  assign hit1     = r.pv[1] && (r.pline[1] == if_line);
  assign if_hit   = r.pf_en && (hit0 || hit1);
  assign dr_hit   = r.dc_en && r.cv && (r.cline == dr_line);
  // A request is held until its ack, so the ack cycle itself is not a new request
  assign if_take  = i_if_req && !r.if_ack;
  assign dr_take  = i_dr_req && !r.dr_ack;
  assign acc_done = (r.st == FRC_ACC) && (r.cnt == 4'h0);

  // ==========================================================================
  // Error accounting
  assign sbe_inc  = acc_done ? ({1'b0, ecc_lo.sbe} + {1'b0, ecc_hi.sbe}) : 2'b00;
  assign dbe_ev   = acc_done && (ecc_lo.dbe || ecc_hi.dbe);
  assign apb_setup = i_psel && !i_penable;
  assign apb_acc   = i_psel && i_penable;
  assign cnt_clr  = apb_acc && i_pwrite && (i_paddr == `FRC_OFF_CNT);
  assign cnt_base = cnt_clr ? 16'h0000 : r.sbe_cnt;
  assign cnt_sum  = {1'b0, cnt_base} + {15'h0000, sbe_inc};
  // Saturate rather than wrap so a flood of errors never looks like silence
  assign sat_cnt  = cnt_sum[16] ? `FRC_CNT_MAX : cnt_sum[15:0];
  assign thr_ev   = (r.thr != 16'h0000) && (sat_cnt >= r.thr)
                    && (cnt_base < r.thr);
  // Only bits already returned to software are cleared, so a new event is kept
  assign rd_clr   = (apb_acc && !i_pwrite && (i_paddr == `FRC_OFF_STAT)) ?
                    r.prdata[1:0] : 2'b00;

  // ==========================================================================
  // Register read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    unique case (i_paddr)
      `FRC_OFF_CTRL: begin
        rd_val[`FRC_CTRL_PF]                       = r.pf_en;
        rd_val[`FRC_CTRL_DC]                       = r.dc_en;
        rd_val[`FRC_CTRL_WAIT_MSB:`FRC_CTRL_WAIT_LSB] = r.wait_cycles;
      end
      `FRC_OFF_STAT: rd_val[1:0]  = r.stat;
      `FRC_OFF_MASK: rd_val[1:0]  = r.mask;
      `FRC_OFF_THR:  rd_val[15:0] = r.thr;
      `FRC_OFF_CNT:  rd_val[15:0] = r.sbe_cnt;
      default:       mapped       = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    n        = r;
    n.if_ack = 1'b0;
    n.dr_ack = 1'b0;
    hit_line = hit1 ? r.pdata[1] : r.pdata[0];
    fs       = r.pv[0];

    // Sequential fetch served from the buffer
    if (if_take && if_hit) begin
      n.if_ack  = 1'b1;
      n.if_data = hit_line[{i_if_addr[2:0], 4'h0} +: 16];
      // The entry behind the one in use is spent; free it for refill
      if (hit1 && (r.pline[0] != r.pline[1] + 1'b1)) begin
        n.pv[0] = 1'b0;
      end
      if (hit0 && (r.pline[1] != r.pline[0] + 1'b1)) begin
        n.pv[1] = 1'b0;
      end
    end

    if (dr_take && dr_hit) begin
      n.dr_ack  = 1'b1;
      n.dr_data = r.cdata[{i_dr_addr[1:0], 5'h00} +: 32];
    end

    unique case (r.st)
      FRC_IDLE: begin
        // Data reads first: the CPU stalls on them while fetches may still hit
        if (dr_take && !dr_hit) begin
          n.st       = FRC_ACC;
          n.kind     = FRC_K_DR;
          n.cnt      = r.wait_cycles;
          n.acc_line = dr_line;
        end else if (if_take && !if_hit) begin
          n.st       = FRC_ACC;
          n.kind     = FRC_K_IF;
          n.cnt      = r.wait_cycles;
          n.acc_line = if_line;
          n.pv       = 2'b00;
          n.la_v     = 1'b0;
        end else if (r.pf_en && r.la_v && !(&r.pv)) begin
          n.st       = FRC_ACC;
          n.kind     = FRC_K_PF;
          n.cnt      = r.wait_cycles;
          n.acc_line = r.la_line;
        end
      end
      FRC_ACC: begin
        if (r.cnt != 4'h0) begin
          n.cnt = r.cnt - 4'h1;
        end else begin
          n.st = FRC_IDLE;
          unique case (r.kind)
            FRC_K_IF: begin
              n.if_ack  = 1'b1;
              n.if_data = fixed_line[{i_if_addr[2:0], 4'h0} +: 16];
              if (r.pf_en) begin
                n.pv[0]    = 1'b1;
                n.pline[0] = r.acc_line;
                n.pdata[0] = fixed_line;
                n.la_v     = 1'b1;
                n.la_line  = r.acc_line + 1'b1;
              end
            end
            FRC_K_PF: begin
              n.pv[fs]    = 1'b1;
              n.pline[fs] = r.acc_line;
              n.pdata[fs] = fixed_line;
              n.la_line   = r.acc_line + 1'b1;
            end
            FRC_K_DR: begin
              n.dr_ack  = 1'b1;
              n.dr_data = fixed_line[{i_dr_addr[1:0], 5'h00} +: 32];
              if (r.dc_en) begin
                n.cv    = 1'b1;
                n.cline = r.acc_line;
                n.cdata = fixed_line;
              end
            end
            default: n.st = FRC_IDLE;
          endcase
        end
      end
    endcase

    // Register bus
    if (apb_setup) begin
      n.prdata = rd_val;
    end
    if (apb_acc && i_pwrite) begin
      unique case (i_paddr)
        `FRC_OFF_CTRL: begin
          n.pf_en = i_pwdata[`FRC_CTRL_PF];
          n.dc_en = i_pwdata[`FRC_CTRL_DC];
          n.wait_cycles = i_pwdata[`FRC_CTRL_WAIT_MSB:`FRC_CTRL_WAIT_LSB];
          // Disabling drops the contents so a later enable starts clean
          if (!i_pwdata[`FRC_CTRL_PF]) begin
            n.pv   = 2'b00;
            n.la_v = 1'b0;
          end
          if (!i_pwdata[`FRC_CTRL_DC]) begin
            n.cv = 1'b0;
          end
        end
        `FRC_OFF_MASK: n.mask = i_pwdata[1:0];
        `FRC_OFF_THR:  n.thr  = i_pwdata[15:0];
        default: ;
      endcase
    end
    n.sbe_cnt = sat_cnt;
    n.stat    = (r.stat & ~rd_clr) | {thr_ev, dbe_ev};
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= RST;
    end else if (i_clk_en) begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_prdata     = r.prdata;
  assign o_pready     = i_clk_en;
  assign o_pslverr    = apb_acc && !mapped;
  assign o_if_ack     = r.if_ack;
  assign o_if_data    = r.if_data;
  assign o_dr_ack     = r.dr_ack;
  assign o_dr_data    = r.dr_data;
  assign o_flash_req  = (r.st == FRC_ACC);
  assign o_flash_addr = r.acc_line;
  assign o_nmi        = r.stat[`FRC_ST_DBE];
  assign o_irq        = |(r.stat & r.mask);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_if_miss;
    i_clk_en && (r.st == FRC_IDLE) && if_take && !if_hit && !dr_take;
  endsequence

  sequence s_if_done;
    i_clk_en && acc_done && (r.kind == FRC_K_IF);
  endsequence

  a_pf_off_wait: assert property (
    (i_clk_en && !r.pf_en && (r.st == FRC_IDLE) && if_take && !dr_take)
    |=> o_flash_req && !o_if_ack)
    else $error("fetch with prefetch off skipped the flash access");

  a_lookahead_next: assert property (
    (s_if_done ##0 r.pf_en) |=> r.la_v && (r.la_line == $past(r.acc_line) + 1'b1))
    else $error("look-ahead does not follow the fetched line");

  a_pf_slot_free: assert property (
    (r.st == FRC_ACC) && (r.kind == FRC_K_PF) |-> !(&r.pv))
    else $error("prefetch running with both entries full");

  a_pf_refill: assert property (
    (i_clk_en && (r.st == FRC_IDLE) && !dr_take && !(if_take && !if_hit)
     && r.pf_en && r.la_v && !(&r.pv))
    |=> (r.kind == FRC_K_PF) && o_flash_req && (o_flash_addr == $past(r.la_line)))
    else $error("free entry not refilled from the look-ahead line");

  a_seq_no_wait: assert property (
    (i_clk_en && if_take && if_hit) |=> o_if_ack)
    else $error("buffered fetch not answered in one cycle");

  a_dc_fill: assert property (
    (i_clk_en && acc_done && (r.kind == FRC_K_DR) && r.dc_en)
    |=> r.cv && (r.cline == $past(r.acc_line)) && o_dr_ack)
    else $error("data line not captured in the cache");

  a_dc_hit: assert property (
    (i_clk_en && dr_take && dr_hit) |=> o_dr_ack)
    else $error("cached data read not answered in one cycle");

  a_dc_off_wait: assert property (
    (i_clk_en && !r.dc_en && dr_take && (r.st == FRC_IDLE))
    |=> o_flash_req && (r.kind == FRC_K_DR))
    else $error("uncached data read skipped the flash access");

  a_ecc_no_cycle: assert property (
    s_if_done |=> o_if_ack)
    else $error("ECC check delayed the fetch answer");

  a_nmi_raise: assert property (
    (i_clk_en && dbe_ev) |=> o_nmi [*2])
    else $error("uncorrectable error did not hold the NMI");

  a_thr_irq: assert property (
    (i_clk_en && thr_ev)
    |=> r.stat[`FRC_ST_THR] && (o_irq || !r.mask[`FRC_ST_THR]))
    else $error("threshold reached without interrupt");

  a_miss_flush: assert property (
    s_if_miss |=> (r.pv == 2'b00) && o_flash_req && (o_flash_addr == $past(if_line)))
    else $error("miss did not flush and restart the buffer");

  a_sbe_count: assert property (
    (i_clk_en && acc_done && (ecc_lo.sbe ^ ecc_hi.sbe) && !cnt_clr
     && (r.sbe_cnt < 16'h8000))
    |=> r.sbe_cnt == $past(r.sbe_cnt) + 16'h0001)
    else $error("corrected error not counted");

endmodule

// File: pkg/frc_defines.svh
// Register offsets, field positions, reset values and widths of the flash read controller
`ifndef FRC_DEFINES_SVH
`define FRC_DEFINES_SVH

// ==========================================================================
// Widths
`define FRC_LINE_W      22
`define FRC_IF_AW       25
`define FRC_DR_AW       24
`define FRC_PADDR_W     12
`define FRC_WAIT_W      4

// ==========================================================================
// Register offsets (byte addresses)
`define FRC_OFF_CTRL    12'h000
`define FRC_OFF_STAT    12'h004
`define FRC_OFF_MASK    12'h008
`define FRC_OFF_THR     12'h00C
`define FRC_OFF_CNT     12'h010

// ==========================================================================
// Field positions
`define FRC_CTRL_PF     0
`define FRC_CTRL_DC     1
`define FRC_CTRL_WAIT_LSB 4
`define FRC_CTRL_WAIT_MSB 7
`define FRC_ST_DBE      0
`define FRC_ST_THR      1

// ==========================================================================
// Reset values and limits
`define FRC_WAIT_RST    4'h3
`define FRC_THR_RST     16'h0000
`define FRC_CNT_MAX     16'hFFFF

`endif

// File: pkg/frc_ecc_if.sv
// Connection between the controller and one 64-bit error check slice
`timescale 1ns/100ps

interface frc_ecc_if;
  logic [63:0] data;
  logic [7:0]  ecc;
  logic [63:0] fixed;
  logic        sbe;
  logic        dbe;

  modport chk  (input data, input ecc, output fixed, output sbe, output dbe);
  modport user (output data, output ecc, input fixed, input sbe, input dbe);
endinterface

// File: pkg/frc_pkg.sv
// Types shared by the flash read controller modules
`include "frc_defines.svh"

package frc_pkg;

  typedef enum logic [0:0] {
    FRC_IDLE = 1'b0,
    FRC_ACC  = 1'b1
  } frc_state_t;

  typedef enum logic [1:0] {
    FRC_K_IF = 2'b00,
    FRC_K_DR = 2'b01,
    FRC_K_PF = 2'b10
  } frc_kind_t;

  typedef struct packed {
    frc_state_t                      st;
    frc_kind_t                       kind;
    logic [`FRC_WAIT_W-1:0]          cnt;
    logic [`FRC_LINE_W-1:0]          acc_line;
    logic [1:0]                      pv;
    logic [1:0][`FRC_LINE_W-1:0]     pline;
    logic [1:0][127:0]               pdata;
    logic                            la_v;
    logic [`FRC_LINE_W-1:0]          la_line;
    logic                            cv;
    logic [`FRC_LINE_W-1:0]          cline;
    logic [127:0]                    cdata;
    logic                            if_ack;
    logic [15:0]                     if_data;
    logic                            dr_ack;
    logic [31:0]                     dr_data;
    logic                            pf_en;
    logic                            dc_en;
    logic [`FRC_WAIT_W-1:0]          wait_cycles;
    logic [1:0]                      stat;
    logic [1:0]                      mask;
    logic [15:0]                     thr;
    logic [15:0]                     sbe_cnt;
    logic [31:0]                     prdata;
  } frc_regs_t;

endpackage

// File: tb/frc_flash_model.sv
// Flash array model: line data with check bits and commanded bit errors
`timescale 1ns/100ps

module frc_flash_model (
  input  wire logic         i_core_clk,
  input  wire logic         i_req,
  input  wire logic [21:0]  i_addr,
  input  wire logic [1:0]   i_err,
  output logic      [127:0] o_data,
  output logic      [15:0]  o_ecc
);
  logic [127:0] raw;
  logic [127:0] last = 128'h0;

  function automatic logic [7:0] ecc_of(input logic [63:0] d);
    logic [7:0] e;
    int         j;
    e = 8'h00;
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[j])
          e[6:0] ^= p[6:0];
        j++;
      end
    end
    e[7] = ^{d, e[6:0]};
    return e;
  endfunction

  // Halfword h of a line holds its own low address bits
  always_comb begin
    for (int h = 0; h < 8; h++)
      raw[16*h +: 16] = {i_addr[12:0], 3'(h)};
  end

  // Idle lines show the inverse of the last word, so a late sample never passes
  always_comb begin
    o_data = ~last;
    o_ecc  = ~{ecc_of(last[127:64]), ecc_of(last[63:0])};
    if (i_req) begin
      o_data = raw ^ {118'h0, i_err[1], 3'h0, |i_err, 5'h0};
      o_ecc  = {ecc_of(raw[127:64]), ecc_of(raw[63:0])};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_req)
      last <= raw;
  end
endmodule

// File: tb/tb.sv
// Bench of the flash read controller: APB, fetch, data read and ECC
`timescale 1ns/100ps
`include "frc_defines.svh"

module tb;
  // Access cycles: 125 MHz core over a 50 MHz array, rounded up
  localparam int WAIT_CYCLES = (125 + 50 - 1) / 50 - 1;
  localparam int MISS        = WAIT_CYCLES + 3;
  localparam int HIT         = 2;
  logic         clk        = 1'b0;
  logic         clk_en     = 1'b1;
  logic         rstn       = 1'b0;
  logic         psel       = 1'b0;
  logic         pen        = 1'b0;
  logic         pwr        = 1'b0;
  logic [11:0]  paddr      = 12'h000;
  logic [31:0]  pwdata     = 32'h0000_0000;
  logic         if_req     = 1'b0;
  logic [24:0]  if_addr    = 25'h000_0000;
  logic         dr_req     = 1'b0;
  logic [23:0]  dr_addr    = 24'h00_0000;
  logic [1:0]   err        = 2'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         if_ack;
  logic [15:0]  if_data;
  logic         dr_ack;
  logic [31:0]  dr_data;
  logic         freq;
  logic [21:0]  faddr;
  logic [127:0] fdata;
  logic [15:0]  fecc;
  logic         nmi;
  logic         irq;
  logic [31:0]  rd;
  int           err_count  = 0;
  int           num_checks = 0;
  int           cyc        = 0;

  frc_top i_frc_top (
    .i_core_clk   (clk),
    .i_resetn     (rstn),
    .i_clk_en     (clk_en),
    .i_psel       (psel),
    .i_penable    (pen),
    .i_pwrite     (pwr),
    .i_paddr      (paddr),
    .i_pwdata     (pwdata),
    .o_prdata     (prdata),
    .o_pready     (pready),
    .o_pslverr    (pslverr),
    .i_if_req     (if_req),
    .i_if_addr    (if_addr),
    .o_if_ack     (if_ack),
    .o_if_data    (if_data),
    .i_dr_req     (dr_req),
    .i_dr_addr    (dr_addr),
    .o_dr_ack     (dr_ack),
    .o_dr_data    (dr_data),
    .o_flash_req  (freq),
    .o_flash_addr (faddr),
    .i_flash_data (fdata),
    .i_flash_ecc  (fecc),
    .o_nmi        (nmi),
    .o_irq        (irq)
  );

  frc_flash_model i_frc_flash_model (
    .i_core_clk (clk),
    .i_req      (freq),
    .i_addr     (faddr),
    .i_err      (err),
    .o_data     (fdata),
    .o_ecc      (fecc)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cyc(input int n, input int e);
    num_checks++;
    if (n != e) begin
      err_count++;
      $display("unexpected at %0t: %0d cycles, expected %0d", $time, n, e);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic se);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r  = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic se;
    apb(1'b1, a, d, rd, se);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic es);
    logic se;
    apb(1'b0, a, 32'h0000_0000, rd, se);
    chk(rd, e);
    chk({31'h0, se}, {31'h0, es});
  endtask

  task automatic cfg(input logic pf, input logic dc);
    wr(`FRC_OFF_CTRL, {24'h00_0000, 4'(WAIT_CYCLES), 2'b00, dc, pf});
  endtask

  // Fetch (d=0) or data read (d=1); checks data and cycles to the answer
  task automatic acc(input logic d, input logic [24:0] a, input int en);
    int          n;
    logic [31:0] v;
    @(posedge clk);
    if (d) begin
      dr_req  <= 1'b1;
      dr_addr <= a[23:0];
    end else begin
      if_req  <= 1'b1;
      if_addr <= a;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((d ? dr_ack : if_ack) !== 1'b1 && n < 40);
    v = d ? dr_data : {16'h0, if_data};
    @(posedge clk);
    if_req <= 1'b0;
    dr_req <= 1'b0;
    chk(v, d ? {a[14:0], 1'b1, a[14:0], 1'b0} : {16'h0, a[15:0]});
    chk_cyc(n, en);
  endtask

  task automatic seq(input logic [24:0] b);
    for (int i = 0; i < 16; i++)
      acc(1'b0, b + 25'(i), (i == 0) ? MISS : HIT);
    repeat (20) @(posedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rdchk(12'(4 * i), (i == 0) ? 32'h0000_0030 : 32'h0000_0000, 1'b0);
    rdchk(12'h020, 32'h0000_0000, 1'b1);
    $display("test registers done");
    cfg(1'b0, 1'b0);
    acc(1'b0, 25'h000_0100, MISS);
    acc(1'b0, 25'h000_0101, MISS);
    acc(1'b1, 25'h000_0200, MISS);
    acc(1'b1, 25'h000_0201, MISS);
    $display("test uncached done");
    cfg(1'b1, 1'b0);
    seq(25'h000_0400);
    seq(25'h001_2340);
    $display("test prefetch done");
    cfg(1'b0, 1'b1);
    acc(1'b1, 25'h000_0300, MISS);
    acc(1'b1, 25'h000_0303, HIT);
    acc(1'b1, 25'h000_0301, HIT);
    acc(1'b1, 25'h000_0304, MISS);
    acc(1'b1, 25'h000_0302, MISS);
    $display("test data cache done");
    cfg(1'b0, 1'b0);
    wr(`FRC_OFF_THR, 32'h0000_0002);
    err <= 2'h1;
    acc(1'b0, 25'h000_0500, MISS);
    acc(1'b0, 25'h000_0508, MISS);
    err <= 2'h0;
    rdchk(`FRC_OFF_CNT, 32'h0000_0002, 1'b0);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`FRC_OFF_MASK, 32'h0000_0002);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    rdchk(`FRC_OFF_STAT, 32'h0000_0002, 1'b0);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`FRC_OFF_CNT, 32'h0000_0000);
    rdchk(`FRC_OFF_CNT, 32'h0000_0000, 1'b0);
    err <= 2'h2;
    acc(1'b0, 25'h000_0601, MISS);
    err <= 2'h0;
    @(negedge clk);
    chk({30'h0, nmi, irq}, 32'h0000_0002);
    rdchk(`FRC_OFF_STAT, 32'h0000_0001, 1'b0);
    @(negedge clk);
    chk({31'h0, nmi}, 32'h0000_0000);
    $display("test ecc done");
    // Clock enable low mid-access: the access stretches by the frozen cycles
    fork
      acc(1'b0, 25'h000_0700, MISS + 3);
      begin
        repeat (2) @(posedge clk);
        clk_en <= 1'b0;
        @(negedge clk);
        chk({31'h0, pready}, 32'h0000_0000);
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    $display("test clock enable done");
    end_sim();
  end
endmodule
